// ===== dv/smarb_arbiter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module smarb_sva (
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  input wire logic                   memory_request_n,
  input wire logic                   chip_select_n,
  input wire logic                   slave_addr_strobe,
  input wire logic                   bus_mode_select,
  input wire logic                   master_active,
  input wire logic                   first_bus_state,
  input wire logic                   slave_memory_ack_n,
  input wire logic                   mem_out_en,
  input wire logic                   operational,
  input wire smarb_pkg::smarb_regs_t regs
);
  import smarb_pkg::*;
  wire strobe_on = slave_addr_strobe != bus_mode_select;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_req_idle;
    $fell(memory_request_n) && chip_select_n && !master_active && first_bus_state;
  endsequence
  sequence s_req_mstr;
    $fell(memory_request_n) && chip_select_n && master_active;
  endsequence
  property p_idle;
    s_req_idle |-> ##[1:8] !slave_memory_ack_n;
  endproperty
  a_idle: assert property (p_idle) else $error("idle grant late");
  property p_mstr;
    s_req_mstr |-> slave_memory_ack_n[*5] ##[1:40] !slave_memory_ack_n;
  endproperty
  a_mstr: assert property (p_mstr) else $error("master grant timing");
  property p_drop;
    (memory_request_n && chip_select_n)[*4] |=> slave_memory_ack_n;
  endproperty
  a_drop: assert property (p_drop) else $error("ack kept after release");
  property p_strobe;
    (memory_request_n && !strobe_on)[*4] |=> slave_memory_ack_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("ack without strobe");
  property p_hold;
    !slave_memory_ack_n && !memory_request_n ##1 !memory_request_n |-> !slave_memory_ack_n;
  endproperty
  a_hold: assert property (p_hold) else $error("ack dropped while held");
  property p_float;
    !slave_memory_ack_n && !memory_request_n |-> !mem_out_en;
  endproperty
  a_float: assert property (p_float) else $error("memory pins driven");
  property p_rst;
    $rose(arst_n) |-> slave_memory_ack_n && !operational ##1 operational;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  property p_cmd;
    $rose(arst_n) |-> regs.command_reg == CMD_HW_RST;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command image");
  property p_clr;
    $rose(arst_n) |-> (regs.interrupt_mask_reg | regs.interrupt_status_reg) == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("interrupt regs not clear");
endmodule
bind smarb_arbiter smarb_sva u_sva (
  .ref_clk, .arst_n, .memory_request_n, .chip_select_n, .slave_addr_strobe,
  .bus_mode_select, .master_active, .first_bus_state, .slave_memory_ack_n,
  .mem_out_en, .operational, .regs
);
`default_nettype wire

// ===== dv/smarb_host.sv
`timescale 1ns/1ps
`default_nettype none
module smarb_host (
  input  wire logic ref_clk,
  input  wire logic bus_mode_select,
  input  wire logic slave_memory_ack_n,
  output var  logic memory_request_n,
  output var  logic chip_select_n,
  output var  logic slave_addr_strobe
);
  initial
  begin
    memory_request_n = 1'b1;
    chip_select_n = 1'b1;
    slave_addr_strobe = 1'b1;
  end
  // Claim memory or a register slot; lat counts clocks to the grant
  task automatic take(input bit cs, input bit strb, output int lat);
    lat = 0;
    @(posedge ref_clk);
    if (cs)
    begin
      chip_select_n <= 1'b0;
      slave_addr_strobe <= strb ^ bus_mode_select;
    end
    else
      memory_request_n <= 1'b0;
    do
    begin
      @(posedge ref_clk);
      lat++;
    end
    while (slave_memory_ack_n !== 1'b0 && lat < 60);
  endtask
  task automatic give();
    @(posedge ref_clk);
    memory_request_n <= 1'b1;
    chip_select_n <= 1'b1;
    slave_addr_strobe <= bus_mode_select;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smarb_pkg::*;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        bus_mode_select = 1'b1;
  logic        master_active = 1'b0;
  logic        first_bus_state = 1'b1;
  logic [3:0]  master_wait_states = 4'h0;
  logic        soft_reset_cmd = 1'b0;
  logic        soft_reset_alt = 1'b0;
  logic        reg_wr_en = 1'b0;
  smarb_regs_t reg_wr_data = '0;
  smarb_mem_t  mem_out_int = '0;
  logic        memory_request_n, chip_select_n, slave_addr_strobe, slave_memory_ack_n;
  logic        slave_cycle, dma_stop, irq_enable, mem_out_en, operational;
  logic        hold_on_falling, packet_compress_out, cam_reject_match;
  smarb_regs_t regs;
  int          fails = 0;
  int          compares = 0;
  int          li, lm, lw, lc;
  always #12.5 ref_clk = ~ref_clk;
  smarb_arbiter uut (
    .ref_clk, .arst_n, .memory_request_n, .chip_select_n, .slave_addr_strobe,
    .bus_mode_select, .master_active, .first_bus_state, .master_wait_states,
    .soft_reset_cmd, .soft_reset_alt, .reg_wr_data, .reg_wr_en, .mem_out_int,
    .slave_memory_ack_n, .slave_cycle, .master_grant(), .dma_stop, .irq_enable, .regs,
    .mem_out(), .mem_out_en, .hold_on_falling, .packet_compress_out, .cam_reject_match,
    .operational
  );
  smarb_host u_host (
    .ref_clk, .bus_mode_select, .slave_memory_ack_n, .memory_request_n, .chip_select_n,
    .slave_addr_strobe
  );
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rst();
    chk("command", regs.command_reg, CMD_HW_RST);
    chk("int_mask", regs.interrupt_mask_reg, IMR_RST);
    chk("int_stat", regs.interrupt_status_reg, ISR_RST);
    chk("tx_ctrl", regs.transmit_control_reg, TCR_RST);
    chk("eob_count", regs.end_of_buffer_count, END_OF_BUFFER_COUNT_RST);
    chk("seq", regs.seq_counters, SEQ_RST);
    chk("cam_en", regs.cam_enable_reg, CAMEN_RST);
    chk("rx_ctrl", regs.receive_control_reg & RCR_HW_CLR, 16'h0000);
    chk("dcfg", regs.data_config_reg & DCR_HW_CLR, 16'h0000);
    chk("dcfg_ext", regs.data_config_ext_reg & DATA_CONFIG_EXT_REG_HW_CLR, 16'h0000);
    chk("flags", 16'({hold_on_falling, packet_compress_out, cam_reject_match}), 16'h0004);
    chk("oper", 16'(operational), 16'h0001);
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (40) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_rst();
    $display("test reset done");
    u_host.take(1'b0, 1'b1, li);
    @(negedge ref_clk);
    chk("mem_oe", 16'(mem_out_en), 16'h0000);
    chk("granted", 16'(li < 60), 16'h0001);
    u_host.give();
    chk("ack_off", 16'(slave_memory_ack_n), 16'h0001);
    master_active <= 1'b1;
    u_host.take(1'b0, 1'b1, lm);
    @(negedge ref_clk);
    chk("mem_oe_m", 16'(mem_out_en), 16'h0000);
    u_host.give();
    chk("mstr_lat", 16'(lm), 16'(li + 4));
    master_wait_states <= 4'h3;
    u_host.take(1'b0, 1'b1, lw);
    u_host.give();
    chk("wait_lat", 16'(lw), 16'(lm + 3));
    master_active <= 1'b0;
    master_wait_states <= 4'h0;
    $display("test memory grant done");
    for (int m = 0; m < 2; m++)
    begin
      bus_mode_select <= m[0];
      u_host.take(1'b1, 1'b1, lc);
      @(negedge ref_clk);
      chk("slave", 16'(slave_cycle), 16'h0001);
      chk("cs_lat", 16'(lc), 16'(li - 2));
      u_host.give();
      u_host.take(1'b1, 1'b0, lc);
      chk("no_strobe", 16'(lc), 16'h003c);
      u_host.give();
    end
    $display("test register slot done");
    for (int a = 0; a < 2; a++)
    begin
      @(posedge ref_clk);
      reg_wr_data <= '1;
      reg_wr_en <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      soft_reset_alt <= a[0];
      soft_reset_cmd <= 1'b1;
      @(posedge ref_clk);
      soft_reset_cmd <= 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("sw_cmd", regs.command_reg, a ? CMD_SW_RST_B : CMD_HW_RST);
      chk("sw_keep", regs.end_of_buffer_count, 16'hffff);
      chk("dma_irq", 16'({dma_stop, irq_enable}), 16'h0002);
    end
    $display("test soft reset done");
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (40) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_rst();
    chk("rx_keep", regs.receive_control_reg, 16'hffff & ~RCR_HW_CLR);
    chk("dcfg_keep", regs.data_config_reg, 16'hffff & ~DCR_HW_CLR);
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// ===== hw/smarb_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Host raises memory_request, gets slave_memory_ack, releases by dropping request.
// - Request sampled on falling clock edge, then two-stage synchronised to rising.
// - Acknowledge is driven from a falling edge in the first bus state.
// - Idle: ack one clock after sample; mastering: ack five clocks after.
// - Each wait state of the current master access adds one clock, up to 11 wait states.
// - Ack drops within four clocks of request removal; master work resumes.
// - Memory ack stays asserted for as long as the request is held.
// - Chip select releases the bus the same way, then enters slave cycle.
// - Chip select ack also needs active address strobe, lasting only while active.
// - Device stays inactive after power-on until a hardware reset occurs.
// - Hardware reset loads command register with 0094h.
// - Hardware reset clears interrupt mask and status registers.
// - Hardware reset loads transmit control with 0101h.
// - Hardware reset sets end-of-buffer count to 02F8h.
// - Hardware reset zeroes sequence counters and address-filter enable.
// - Hardware reset clears loopback and broadcast bits of receive control only.
// - Hardware reset clears data config bits 15,13 and extension bits 4..0.
// - After reset hold request uses falling edge, compress off, matches accepted.
// - Software reset stops DMA and interrupts, leaves registers reachable, idle.
// - Software reset changes only the command register.
module smarb_arbiter #(
  parameter int WAIT_W = 4
) (
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire logic                      memory_request_n,
  input  wire logic                      chip_select_n,
  input  wire logic                      slave_addr_strobe,
  input  wire logic                      bus_mode_select,
  input  wire logic                      master_active,
  input  wire logic                      first_bus_state,
  input  wire logic [WAIT_W-1:0]         master_wait_states,
  input  wire logic                      soft_reset_cmd,
  input  wire logic                      soft_reset_alt,
  input  wire smarb_pkg::smarb_regs_t    reg_wr_data,
  input  wire logic                      reg_wr_en,
  input  wire smarb_pkg::smarb_mem_t     mem_out_int,
  output var  logic                      slave_memory_ack_n,
  output var  logic                      slave_cycle,
  output var  logic                      master_grant,
  output var  logic                      dma_stop,
  output var  logic                      irq_enable,
  output var  smarb_pkg::smarb_regs_t    regs,
  output var  smarb_pkg::smarb_mem_t     mem_out,
  output var  logic                      mem_out_en,
  output var  logic                      hold_on_falling,
  output var  logic                      packet_compress_out,
  output var  logic                      cam_reject_match,
  output var  logic                      operational
);
  import smarb_pkg::*;

  logic             req_fall_ff;
  logic             req_s1_ff;
  logic             req_s2_ff;
  logic             cs_prev_ff;
  logic [1:0]       gap_ff;
  logic [3:0]       cnt_ff;
  logic             wait_mem_ff;
  logic             ack_ff;
  logic             ack_fall_ff;
  logic             oper_ff;
  smarb_state_t     state_ff;
  smarb_state_t     nxt_state;
  logic [3:0]       nxt_cnt;
  smarb_regs_t      nxt_regs;
  smarb_regs_t      regs_ff;
  logic [15:0]      rcr_ff;
  logic [15:0]      dcr_ff;
  logic [15:0]      data_config_ext_reg_ff;

  wire cs_act    = ~chip_select_n;
  wire sas_act   = bus_mode_select ? ~slave_addr_strobe : slave_addr_strobe;
  wire gap_ok    = (gap_ff == 2'h0);
  wire mem_req   = req_s2_ff;
  wire cs_req    = cs_act & sas_act & gap_ok;
  wire any_req   = mem_req | cs_req;
  wire [3:0] mst_delay = ACK_MSTR_CLKS + 4'(master_wait_states);
  wire [3:0] delay     = master_active ? mst_delay : ACK_IDLE_CLKS;
  wire hold_ok   = wait_mem_ff ? mem_req : cs_req;

  // Falling edge capture of asynchronous request
  always_ff @(negedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      req_fall_ff <= 1'b0;
    else
      req_fall_ff <= ~memory_request_n;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end
    else
    begin
      req_s1_ff <= req_fall_ff;
      req_s2_ff <= req_s1_ff;
    end
  end

  // Spacing after chip select and memory request are both released
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_prev_ff <= 1'b0;
      gap_ff     <= 2'h0;
    end
    else
    begin
      cs_prev_ff <= cs_act | mem_req;
      gap_ff     <= (cs_prev_ff & ~(cs_act | mem_req)) ? CS_MEMORY_REQUEST_GAP
                  : (gap_ff != 2'h0) ? gap_ff - 2'h1 : 2'h0;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      SMARB_IDLE:
        if (any_req & oper_ff)
        begin
          nxt_state = SMARB_WAIT;
          nxt_cnt   = delay - 4'h1;
        end
      SMARB_WAIT:
        if (!hold_ok)
          nxt_state = SMARB_IDLE;
        else if (cnt_ff == 4'h0 && first_bus_state)
          nxt_state = wait_mem_ff ? SMARB_GRANT : SMARB_SLAVE;
        else if (cnt_ff != 4'h0)
          nxt_cnt = cnt_ff - 4'h1;
      SMARB_GRANT:
        if (!mem_req)
          nxt_state = SMARB_IDLE;
      SMARB_SLAVE:
        if (!cs_req)
          nxt_state = SMARB_IDLE;
      default:
        nxt_state = SMARB_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff    <= SMARB_IDLE;
      cnt_ff      <= 4'h0;
      wait_mem_ff <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      if (state_ff == SMARB_IDLE)
        wait_mem_ff <= mem_req;
    end
  end

  // Ack held through the whole grant
  wire ack_nxt = (nxt_state == SMARB_GRANT) | (nxt_state == SMARB_SLAVE);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= ack_nxt;
  end

  // Ack launched from the falling edge
  always_ff @(negedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_fall_ff <= 1'b0;
    else
      ack_fall_ff <= ack_ff;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      oper_ff <= 1'b0;
    else
      oper_ff <= 1'b1;
  end

  assign slave_memory_ack_n = ~ack_fall_ff;
  assign slave_cycle        = (state_ff == SMARB_SLAVE);
  assign master_grant       = oper_ff & (state_ff == SMARB_IDLE) & ~regs.command_reg[CMD_RST_BIT];
  assign operational        = oper_ff;

  // Memory pins released during host grant
  assign mem_out    = mem_out_int;
  assign mem_out_en = oper_ff & ~ack_ff & ~ack_fall_ff & master_active;

  // Software reset effects
  assign dma_stop   = regs.command_reg[CMD_RST_BIT];
  assign irq_enable = oper_ff & ~regs.command_reg[CMD_RST_BIT];

  // Register images; writes from the register file merge here
  always_comb
  begin
    nxt_regs = reg_wr_en ? reg_wr_data : regs;
    if (soft_reset_cmd)
      nxt_regs.command_reg = soft_reset_alt ? CMD_SW_RST_B : CMD_HW_RST;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regs_ff.command_reg          <= CMD_HW_RST;
      regs_ff.interrupt_mask_reg   <= IMR_RST;
      regs_ff.interrupt_status_reg <= ISR_RST;
      regs_ff.transmit_control_reg <= TCR_RST;
      regs_ff.end_of_buffer_count  <= END_OF_BUFFER_COUNT_RST;
      regs_ff.seq_counters         <= SEQ_RST;
      regs_ff.cam_enable_reg       <= CAMEN_RST;
      regs_ff.receive_control_reg  <= 16'h0000;
      regs_ff.data_config_reg      <= 16'h0000;
      regs_ff.data_config_ext_reg  <= 16'h0000;
    end
    else
      regs_ff <= nxt_regs;
  end

  // Partly cleared registers: no async reset, so the kept bits survive the pin
  always_ff @(posedge ref_clk)
  begin
    if (!arst_n)
    begin
      rcr_ff  <= rcr_ff & ~RCR_HW_CLR;
      dcr_ff  <= dcr_ff & ~DCR_HW_CLR;
      data_config_ext_reg_ff <= data_config_ext_reg_ff & ~DATA_CONFIG_EXT_REG_HW_CLR;
    end
    else
    begin
      rcr_ff  <= nxt_regs.receive_control_reg;
      dcr_ff  <= nxt_regs.data_config_reg;
      data_config_ext_reg_ff <= nxt_regs.data_config_ext_reg;
    end
  end

  always_comb
  begin
    regs                     = regs_ff;
    regs.receive_control_reg = rcr_ff;
    regs.data_config_reg     = dcr_ff;
    regs.data_config_ext_reg = data_config_ext_reg_ff;
  end

  // Extension bits after reset: falling-edge hold, no compress, accept
  assign hold_on_falling     = ~regs.data_config_ext_reg[0];
  assign packet_compress_out = regs.data_config_ext_reg[1];
  assign cam_reject_match    = regs.data_config_ext_reg[2];

endmodule

`default_nettype wire

// ===== hw/smarb_pkg.sv
package smarb_pkg;

  // Reset images of the affected registers
  localparam logic [15:0] CMD_HW_RST     = 16'h0094;
  localparam logic [15:0] CMD_SW_RST_B   = 16'h00a4;
  localparam logic [15:0] IMR_RST        = 16'h0000;
  localparam logic [15:0] ISR_RST        = 16'h0000;
  localparam logic [15:0] TCR_RST        = 16'h0101;
  localparam logic [15:0] END_OF_BUFFER_COUNT_RST       = 16'h02f8;
  localparam logic [15:0] SEQ_RST        = 16'h0000;
  localparam logic [15:0] CAMEN_RST      = 16'h0000;
  // Receive control: loopback hi/lo and broadcast accept cleared by pin reset
  localparam logic [15:0] RCR_HW_CLR     = 16'h0e00;
  // Data config bits 15 and 13; extension bits 4..0
  localparam logic [15:0] DCR_HW_CLR     = 16'ha000;
  localparam logic [15:0] DATA_CONFIG_EXT_REG_HW_CLR    = 16'h001f;
  // Command register software reset bit position
  localparam int          CMD_RST_BIT    = 7;
  // Grant timing in bus clocks
  localparam logic [3:0]  ACK_IDLE_CLKS  = 4'h1;
  localparam logic [3:0]  ACK_MSTR_CLKS  = 4'h5;
  localparam logic [1:0]  CS_MEMORY_REQUEST_GAP    = 2'h2;

  typedef enum logic [1:0] {
    SMARB_IDLE  = 2'b00,
    SMARB_WAIT  = 2'b01,
    SMARB_GRANT = 2'b11,
    SMARB_SLAVE = 2'b10
  } smarb_state_t;

  // Master memory outputs, released while the host holds the memory
  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] data;
    logic        strobe_n;
  } smarb_mem_t;

  // Register contents loaded by the two resets
  typedef struct packed {
    logic [15:0] command_reg;
    logic [15:0] interrupt_mask_reg;
    logic [15:0] interrupt_status_reg;
    logic [15:0] transmit_control_reg;
    logic [15:0] receive_control_reg;
    logic [15:0] data_config_reg;
    logic [15:0] data_config_ext_reg;
    logic [15:0] end_of_buffer_count;
    logic [15:0] seq_counters;
    logic [15:0] cam_enable_reg;
  } smarb_regs_t;

endpackage
